// *** rtl/rpm_pin_mux.sv ***
// Pin mux for the reset pin (port A bit 7) and port A pins 0 to 3
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
module rpm_pin_mux (
    // Clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    // Other reset sources, active high, same clock domain
    input  wire logic        por_reset,
    input  wire logic        watchdog_reset,
    input  wire logic        sw_reset,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // PWM channels from the PWM block
    input  wire logic        pwm_channel0_out,
    input  wire logic        pwm_channel1_out,
    input  wire logic        pwm_channel2_out,
    input  wire logic        pwm_channel3_out,
    // Reset / port A bit 7 pin
    input  wire logic        port_a_bit7_io_i,
    output logic             port_a_bit7_io_o,
    output logic             port_a_bit7_io_oe,
    output logic             port_a_bit7_pu_en,
    // Port A bits 0 to 3
    input  wire logic [3:0]  port_a_io_i,
    output logic      [3:0]  port_a_io_o,
    output logic      [3:0]  port_a_io_oe,
    output logic      [3:0]  port_a_pu_en,
    // Internal chip reset, active low
    output logic             chip_rstn
);
    import rpm_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [4:0] func_sel_q;   // 1 = alternate function
    logic [4:0] dir_q;        // 1 = output (bit 4: open-drain drive low enable)
    logic [4:0] dout_q;       // Output data
    logic [1:0] rst_pin_sync_q; // Reset pin synchroniser
    logic [4:0] pa_sync1_q;   // First stage for port A inputs
    logic [4:0] pa_sync2_q;   // Second stage for port A inputs
    logic       pin_rst_req;  // Reset pin asserted while in reset mode
    logic       rst_req;      // Any reset source
    logic       int_rstn;     // Released internal reset
    logic [3:0] pwm_vec;      // PWM channels 0 to 3
    logic       last_pin_rst_q; // Captured cause, pin reset seen

    assign pwm_vec = {pwm_channel3_out, pwm_channel2_out,
                      pwm_channel1_out, pwm_channel0_out};

    // Decode a register address against a given offset
    function automatic logic addr_hit(input logic [3:0] a, input logic [3:0] off);
        addr_hit = (a == off);
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Reset pin stages start at the released level, so an unknown or low
    // value left over from power-up cannot pose as a pin reset request
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rst_pin_sync_q <= 2'b11;
        end else if (clk_en) begin
            rst_pin_sync_q <= {rst_pin_sync_q[0], port_a_bit7_io_i};
        end
    end

    // Pin levels come from outside the clock domain; two stages each
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            pa_sync1_q     <= {port_a_bit7_io_i, port_a_io_i};
            pa_sync2_q     <= pa_sync1_q;
        end
    end

    // ----------------------------------------
    // Reset request combine
    // ----------------------------------------
    // Pin counts as reset only in reset-pin mode, see R3, R6
    assign pin_rst_req = ~rst_pin_sync_q[1] & ~func_sel_q[RPM_FSEL_BIT7_POS];
    // In bit 7 mode only rstn, power-on, watchdog or software resets remain, see R6
    assign rst_req     = ~rstn | por_reset | watchdog_reset | sw_reset | pin_rst_req;

    // Release sequencer, see R4, R12
    rpm_rst_release u_release (
        .core_clk (core_clk),
        .clk_en   (clk_en),
        .rst_req  (rst_req),
        .int_rstn (int_rstn)
    );

    // Whole chip held while request or count is active, see R3
    assign chip_rstn = int_rstn;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Cleared by every reset source so the pins fall back to primary
    // function, including the reset pin itself, see R1, R7, R10
    always_ff @(posedge core_clk) begin
        if (!int_rstn) begin
            func_sel_q <= RPM_FUNC_SEL_RST;
            dir_q      <= RPM_DIR_RST;
            dout_q     <= RPM_DATA_OUT_RST;
        end else if (clk_en && reg_wr) begin
            // Alternate function only once software writes it, see R2
            if (addr_hit(reg_addr, RPM_ADDR_FUNC_SEL)) begin
                func_sel_q <= reg_wdata[4:0];
            end
            // Each bit independent, see R8
            if (addr_hit(reg_addr, RPM_ADDR_DIR)) begin
                dir_q <= reg_wdata[4:0];
            end
            if (addr_hit(reg_addr, RPM_ADDR_DATA_OUT)) begin
                dout_q <= reg_wdata[4:0];
            end
        end
    end

    // Sticky cause bit: pin reset observed, cleared by rstn or power-on only
    always_ff @(posedge core_clk) begin
        if (!rstn || por_reset) begin
            last_pin_rst_q <= 1'b0;
        end else if (clk_en && pin_rst_req) begin
            last_pin_rst_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            if (reg_rd) begin
                case (reg_addr)
                    RPM_ADDR_FUNC_SEL: reg_rdata <= {3'h0, func_sel_q};
                    RPM_ADDR_DIR:      reg_rdata <= {3'h0, dir_q};
                    RPM_ADDR_DATA_OUT: reg_rdata <= {3'h0, dout_q};
                    RPM_ADDR_DATA_IN:  reg_rdata <= {3'h0, pa_sync2_q};
                    RPM_ADDR_STATUS:   reg_rdata <= {6'h00, last_pin_rst_q, int_rstn};
                    default:           reg_rdata <= 8'h00;   // Unmapped reads zero
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // ----------------------------------------
    // Port A bits 0 to 3 drivers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_pa
            always_ff @(posedge core_clk) begin
                if (!int_rstn) begin
                    // Input with pull-up during reset, see R11
                    port_a_io_o[g]  <= 1'b0;
                    port_a_io_oe[g] <= 1'b0;
                    port_a_pu_en[g] <= 1'b1;
                end else if (clk_en) begin
                    if (func_sel_q[g]) begin
                        // PWM channel g, output only, see R9
                        port_a_io_o[g]  <= pwm_vec[g];
                        port_a_io_oe[g] <= 1'b1;
                        port_a_pu_en[g] <= 1'b0;
                    end else begin
                        // Own direction per pin, see R8
                        port_a_io_o[g]  <= dout_q[g];
                        port_a_io_oe[g] <= dir_q[g];
                        port_a_pu_en[g] <= ~dir_q[g];
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Reset pin / port A bit 7 driver
    // ----------------------------------------
    // Open drain only: it may pull low, never drive high, see R5
    always_ff @(posedge core_clk) begin
        if (!int_rstn) begin
            port_a_bit7_io_o  <= 1'b0;
            port_a_bit7_io_oe <= 1'b0;   // Reset input with pull-up, see R11
            port_a_bit7_pu_en <= 1'b1;
        end else if (clk_en) begin
            port_a_bit7_io_o  <= 1'b0;
            port_a_bit7_io_oe <= func_sel_q[RPM_FSEL_BIT7_POS] & dir_q[RPM_BIT7_POS]
                                 & ~dout_q[RPM_BIT7_POS];   // see R5
            port_a_bit7_pu_en <= 1'b1;
        end
    end

endmodule

// *** pkg/rpm_pkg.sv ***
// Package of constants and types for the reset pin and port A pin mux
//
// Overview of operation
// R1 - Leaving reset, all pins on primary function
// R2 - Software must program alternate function selection
// R3 - Reset pin low holds chip in reset
// R4 - Internal reset released synchronously after fixed count
// R5 - Port A bit 7: input or open-drain only
// R6 - Bit 7 mode ignores pin; other resets only
// R7 - Any reset restores reset-pin function
// R8 - Pins 0-3 have independent directions
// R9 - Alternate: pins 0-3 carry PWM channels 0-3
// R10 - After reset pins 0-3 are general purpose
// R11 - During reset pins inputs with pull-ups
// R12 - Release delay counter restarts on reassertion
package rpm_pkg;

    // ----------------------------------------
    // Register map of the plain register port
    // ----------------------------------------
    localparam logic [3:0] RPM_ADDR_FUNC_SEL = 4'h0;   // Function selection
    localparam logic [3:0] RPM_ADDR_DIR      = 4'h1;   // Direction per pin
    localparam logic [3:0] RPM_ADDR_DATA_OUT = 4'h2;   // Output data per pin
    localparam logic [3:0] RPM_ADDR_DATA_IN  = 4'h3;   // Pin levels (read only)
    localparam logic [3:0] RPM_ADDR_STATUS   = 4'h4;   // Reset status (read only)

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int RPM_FSEL_BIT7_POS = 4;   // Function select bit for reset pin
    localparam int RPM_BIT7_POS      = 4;   // Data/dir bit for port A bit 7

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [4:0] RPM_FUNC_SEL_RST = 5'h00;
    localparam logic [4:0] RPM_DIR_RST      = 5'h00;
    localparam logic [4:0] RPM_DATA_OUT_RST = 5'h00;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int RPM_CLK_MHZ          = 125;
    localparam int RPM_REL_DELAY_CYCLES = 32;   // Fixed internal release count
    localparam int RPM_CNT_W            = 6;

    // Release sequencer states
    typedef enum logic [1:0] {
        RPM_ST_HOLD,
        RPM_ST_COUNT,
        RPM_ST_RUN
    } rpm_state_e;

endpackage

// *** rtl/rpm_rst_release.sv ***
// Reset release sequencer: holds internal reset then releases after a fixed count
`timescale 1ns/10ps
module rpm_rst_release (
    // Clock, enable
    input  wire logic core_clk,
    input  wire logic clk_en,
    // Reset request, already synchronised, active high
    input  wire logic rst_req,
    // Internal reset out, active low
    output logic      int_rstn
);
    import rpm_pkg::*;

    rpm_state_e           state_q;   // Sequencer state
    logic [RPM_CNT_W-1:0] cnt_q;     // Cycles in count state, holds at RPM_REL_DELAY_CYCLES - 1

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // No asynchronous path: the release edge always lines up with core_clk
    always_ff @(posedge core_clk) begin
        if (rst_req) begin
            state_q <= RPM_ST_HOLD;        // Restart on every reassertion, see R12
            cnt_q   <= '0;
        end else if (clk_en) begin
            case (state_q)
                RPM_ST_HOLD: begin
                    state_q <= RPM_ST_COUNT;
                    cnt_q   <= '0;
                end
                RPM_ST_COUNT: begin
                    // Fixed design-time count, see R4
                    if (cnt_q == RPM_CNT_W'(RPM_REL_DELAY_CYCLES - 1)) begin
                        state_q <= RPM_ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + RPM_CNT_W'(1);
                    end
                end
                RPM_ST_RUN: begin
                    state_q <= RPM_ST_RUN;
                end
                default: begin
                    state_q <= RPM_ST_HOLD;
                end
            endcase
        end
    end

    // Registered internal reset, deasserted only in run state, see R4
    always_ff @(posedge core_clk) begin
        if (rst_req) begin
            int_rstn <= 1'b0;
        end else if (clk_en) begin
            int_rstn <= (state_q == RPM_ST_RUN);
        end
    end

endmodule

// *** dv/rpm_pin_mux_properties.sv ***
// Checker of reset release and pin state around resets
`timescale 1ns/10ps
module rpm_pin_mux_properties (
    // Clock and reset sources
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic       por_reset,
    input wire logic       watchdog_reset,
    input wire logic       sw_reset,
    // Register read and pins
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       port_a_bit7_io_i,
    input wire logic       port_a_bit7_io_o,
    input wire logic       port_a_bit7_io_oe,
    input wire logic       port_a_bit7_pu_en,
    input wire logic [3:0] port_a_io_oe,
    input wire logic [3:0] port_a_pu_en,
    input wire logic       chip_rstn
);
    import rpm_pkg::*;
    // ----
    // Cycles since the last reset request
    // ----
    logic [1:0] pin_s_q; // Same depth as the pin synchroniser
    logic [7:0] quiet_q; // Saturates so a long run cannot wrap
    logic       req;     // Pin low counts even in GPIO mode; bench does that only while chip_rstn stays high
    assign req = !rstn || por_reset || watchdog_reset || sw_reset || !pin_s_q[1];
    always_ff @(posedge core_clk) begin
        pin_s_q <= {pin_s_q[0], port_a_bit7_io_i};
    end
    always_ff @(posedge core_clk) begin
        if (req) begin
            quiet_q <= 8'h00;
        end else if (quiet_q != 8'hff) begin
            quiet_q <= quiet_q + 8'h01;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_rst_oe;
        !chip_rstn && !$past(chip_rstn) |-> port_a_io_oe == 4'h0 && !port_a_bit7_io_oe;
    endproperty
    a_rst_oe: assert property (p_rst_oe) else $error("pin driven in reset");
    property p_rst_pu;
        !chip_rstn && !$past(chip_rstn) |-> port_a_pu_en == 4'hf;
    endproperty
    a_rst_pu: assert property (p_rst_pu) else $error("pull-up off in reset");
    property p_bit7_od;
        port_a_bit7_io_o == 1'b0 && port_a_bit7_pu_en;
    endproperty
    a_bit7_od: assert property (p_bit7_od) else $error("bit7 drives high");
    property p_release;
        $rose(chip_rstn) |-> quiet_q == 8'(RPM_REL_DELAY_CYCLES + 2);
    endproperty
    a_release: assert property (p_release) else $error("release count wrong");
    property p_hold;
        por_reset || watchdog_reset || sw_reset |=> !chip_rstn;
    endproperty
    a_hold: assert property (p_hold) else $error("reset source ignored");
    property p_restart;
        $fell(por_reset) |-> !chip_rstn [*8];
    endproperty
    a_restart: assert property (p_restart) else $error("early release");
    property p_post_rst;
        $rose(chip_rstn) |=> port_a_io_oe == 4'h0 && !port_a_bit7_io_oe;
    endproperty
    a_post_rst: assert property (p_post_rst) else $error("pin not primary");
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
endmodule

// *** dv/rpm_board_model.sv ***
// Board model: reset button and loads on the five pins
`timescale 1ns/10ps
module rpm_board_model (
    // Clock
    input wire logic       core_clk,
    // Design drive, bit 4 is the reset pin
    input wire logic [4:0] pin_o,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] pin_pu,
    // Board drive commanded by the bench
    input wire logic [4:0] ext_en,
    input wire logic [4:0] ext_val,
    // Resolved levels
    output logic     [4:0] pin_lvl
);
    logic [4:0] last_q; // A floating pin must not keep its last level
    // Drivers wire-AND; bit 7 can only pull low
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (pin_oe[i] || ext_en[i]) begin
                pin_lvl[i] = (pin_oe[i] ? pin_o[i] : 1'b1) & (ext_en[i] ? ext_val[i] : 1'b1);
            end else begin
                pin_lvl[i] = pin_pu[i] ? 1'b1 : ~last_q[i];
            end
        end
    end
    always_ff @(posedge core_clk) last_q <= pin_lvl;
endmodule

// *** dv/rpm_pin_mux_tb_top.sv ***
// Top testbench of the reset pin and port A pin mux
`timescale 1ns/10ps
module rpm_pin_mux_tb_top;
    import rpm_pkg::*;
    // ----
    // Stimulus and observation
    // ----
    logic       core_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       clk_en = 1'b1;   // Freeze path not exercised here
    logic [2:0] src = 3'h0;      // {por, watchdog, software}
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [3:0] pwm = 4'h0;
    logic [4:0] ext_en = 5'h00;  // Board drive, bit 4 is the reset pin
    logic [4:0] ext_val = 5'h00;
    logic [7:0] reg_rdata;
    logic [4:0] pin_o, pin_oe, pin_pu, pin_lvl;
    logic       chip_rstn;
    int         errors = 0;
    int         comparisons = 0;
    int         n;
    always #4 core_clk = ~core_clk;
    rpm_pin_mux DUT (
        .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
        .por_reset(src[2]), .watchdog_reset(src[1]), .sw_reset(src[0]),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_channel0_out(pwm[0]), .pwm_channel1_out(pwm[1]),
        .pwm_channel2_out(pwm[2]), .pwm_channel3_out(pwm[3]),
        .port_a_bit7_io_i(pin_lvl[4]), .port_a_bit7_io_o(pin_o[4]),
        .port_a_bit7_io_oe(pin_oe[4]), .port_a_bit7_pu_en(pin_pu[4]),
        .port_a_io_i(pin_lvl[3:0]), .port_a_io_o(pin_o[3:0]),
        .port_a_io_oe(pin_oe[3:0]), .port_a_pu_en(pin_pu[3:0]), .chip_rstn(chip_rstn));
    rpm_board_model u_board (.core_clk(core_clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pu(pin_pu), .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_lvl));
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task summarize;
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, exp);
    endtask
    // Register, then pin stage, then one spare edge
    task settle;
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    // Edges from request drop to internal reset release, bounded
    task rel(input int exp);
        n = 0;
        while (chip_rstn !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            #1 n++;
        end
        cmp(8'(n), 8'(exp));
        if (n == 300) summarize();
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        rel(RPM_REL_DELAY_CYCLES + 2);
        settle;
        cmp({3'h0, pin_oe}, 8'h00);
        rd(RPM_ADDR_FUNC_SEL, 8'h00);
        wr(RPM_ADDR_DATA_OUT, 8'h03);
        wr(RPM_ADDR_DIR, 8'h05);
        settle;
        cmp({4'h0, pin_oe[3:0]}, 8'h05);
        cmp({4'h0, pin_o[3:0] & pin_oe[3:0]}, 8'h01);
        wr(RPM_ADDR_DIR, 8'h0a);
        ext_en <= 5'h05;
        ext_val <= 5'h04;
        settle;
        cmp({4'h0, pin_oe[3:0]}, 8'h0a);
        wr(RPM_ADDR_DATA_IN, 8'hff);
        rd(RPM_ADDR_DATA_IN, 8'h16);
        rd(4'h7, 8'h00);
        wr(RPM_ADDR_FUNC_SEL, 8'h0f);
        ext_en <= 5'h00;
        pwm <= 4'ha;
        settle;
        cmp({4'h0, pin_oe[3:0]}, 8'h0f);
        cmp({4'h0, pin_o[3:0]}, 8'h0a);
        @(posedge core_clk);
        pwm <= 4'h5;
        settle;
        cmp({4'h0, pin_o[3:0]}, 8'h05);
        wr(RPM_ADDR_FUNC_SEL, 8'h10);
        wr(RPM_ADDR_DIR, 8'h10);
        settle;
        cmp({6'h0, pin_oe[4], pin_o[4]}, 8'h02);
        wr(RPM_ADDR_DATA_OUT, 8'h10);
        ext_en <= 5'h1f;
        ext_val <= 5'h05;
        settle;
        cmp({6'h0, pin_oe[4], pin_o[4]}, 8'h00);
        repeat (40) @(posedge core_clk);
        #1 cmp({7'h0, chip_rstn}, 8'h01);
        rd(RPM_ADDR_DATA_IN, 8'h05);
        ext_en <= 5'h00;
        for (int i = 0; i < 3; i++) begin
            wr(RPM_ADDR_FUNC_SEL, 8'h1f);
            src <= 3'h1 << i;
            repeat (2) @(posedge core_clk);
            src <= 3'h0;
            rel(RPM_REL_DELAY_CYCLES + 2);
            settle;
            rd(RPM_ADDR_FUNC_SEL, 8'h00);
        end
        @(posedge core_clk);
        src <= 3'h4;
        repeat (2) @(posedge core_clk);
        src <= 3'h0;
        repeat (10) @(posedge core_clk);
        src <= 3'h4;
        @(posedge core_clk);
        src <= 3'h0;
        rel(RPM_REL_DELAY_CYCLES + 2);
        @(posedge core_clk);
        ext_en <= 5'h10;
        repeat (5) @(posedge core_clk);
        wr(RPM_ADDR_FUNC_SEL, 8'h0f);
        repeat (40) @(posedge core_clk);
        #1 cmp({7'h0, chip_rstn}, 8'h00);
        @(posedge core_clk);
        ext_en <= 5'h00;
        rel(RPM_REL_DELAY_CYCLES + 4);
        settle;
        rd(RPM_ADDR_FUNC_SEL, 8'h00);
        rd(RPM_ADDR_STATUS, 8'h03);
        summarize();
    end
endmodule
bind rpm_pin_mux rpm_pin_mux_properties u_props (.core_clk(core_clk), .rstn(rstn),
    .por_reset(por_reset), .watchdog_reset(watchdog_reset), .sw_reset(sw_reset),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_bit7_io_i(port_a_bit7_io_i),
    .port_a_bit7_io_o(port_a_bit7_io_o), .port_a_bit7_io_oe(port_a_bit7_io_oe),
    .port_a_bit7_pu_en(port_a_bit7_pu_en), .port_a_io_oe(port_a_io_oe),
    .port_a_pu_en(port_a_pu_en), .chip_rstn(chip_rstn));
